// >>> rtl/dpt_dma.sv
/*
  Two-channel DMA slice: pointer registers, request-pending flags and the
  transfer engine that spends the documented number of bus cycles per unit.
  Assumes synchronous inputs, a system bus that answers in the last cycle of
  each access, and byte accesses carried on the low data lane.
*/
`timescale 1ns/1ps
module dpt_dma (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [dpt_pkg::RW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [dpt_pkg::RW-1:0] reg_rdata,
  input wire logic [dpt_pkg::NCH-1:0] dma_req,
  input wire logic ext_mode,
  input wire logic byte_pin,
  input wire logic bus_rdy_n,
  input wire logic [dpt_pkg::DW-1:0] bus_rdata,
  output dpt_pkg::dpt_bus_t bus_o
);
  // ****************************************
  // Register state
  // ****************************************
  logic [dpt_pkg::NCH-1:0] en_r, pend_r, sdir_r, ddir_r, u8c_r, ldp_r;
  logic [1:0] sarea_r [dpt_pkg::NCH];
  logic [1:0] darea_r [dpt_pkg::NCH];
  logic [dpt_pkg::AW-1:0] src_r [dpt_pkg::NCH];
  logic [dpt_pkg::AW-1:0] dst_r [dpt_pkg::NCH];
  logic [dpt_pkg::AW-1:0] fwd_r [dpt_pkg::NCH];
  logic [15:0] cnt_r [dpt_pkg::NCH];
  logic [15:0] rld_r [dpt_pkg::NCH];
  logic mem_wait_r, sfr_wait_select_r;
  logic [1:0] cs_wait_r;
  logic [dpt_pkg::IW-1:0] ix;
  logic [dpt_pkg::RW-1:0] rd_nxt;

  // ****************************************
  // Engine state
  // ****************************************
  dpt_pkg::dpt_state_t st_r;
  logic ch_r, part_r, u8_r, uflow_r;
  logic [2:0] wt_r;
  logic [1:0] sa_r, da_r;
  logic [dpt_pkg::AW-1:0] saddr_r, daddr_r, cur_r;
  logic [dpt_pkg::DW-1:0] data_r;
  logic go, pick, bus8, hold, rd2, wr2, last, fin;
  logic [dpt_pkg::AW-1:0] base, s_nxt, d_nxt;
  logic [15:0] cbase;

  assign ix = reg_addr[7:2];
  assign bus8 = ext_mode & byte_pin;
  assign go = (st_r == dpt_pkg::ST_IDLE) && |(en_r & pend_r);
  assign pick = !(en_r[0] & pend_r[0]);
  assign base = ldp_r[pick] ? (sdir_r[pick] ? src_r[pick] : dst_r[pick]) : fwd_r[pick];
  assign cbase = ldp_r[pick] ? rld_r[pick] : cnt_r[pick];
  assign s_nxt = sdir_r[pick] ? base : src_r[pick];
  assign d_nxt = ddir_r[pick] ? base : dst_r[pick];
  assign rd2 = !u8_r && (saddr_r[0] || bus8);
  assign wr2 = !u8_r && (daddr_r[0] || bus8);
  assign hold = ext_mode && bus_rdy_n
    && (((st_r == dpt_pkg::ST_RD) ? sa_r : da_r) inside {dpt_pkg::AR_SEP, dpt_pkg::AR_MUX});
  assign last = (st_r == dpt_pkg::ST_RD) ? (part_r || !rd2) : (part_r || !wr2);
  assign fin = (st_r == dpt_pkg::ST_WR) && (wt_r == 3'h0) && !hold && last;

  // Bus cycles per access for an area and its wait setting
  function automatic logic [2:0] coef(input logic [1:0] area, input logic wr);
    logic [2:0] c;
    c = dpt_pkg::CF_ONE;
    unique case (area)
      dpt_pkg::AR_MEM: c = mem_wait_r ? dpt_pkg::CF_MEM_W : dpt_pkg::CF_ONE;
      dpt_pkg::AR_SFR: c = sfr_wait_select_r ? dpt_pkg::CF_SFR_2W : dpt_pkg::CF_SFR_1W;
      dpt_pkg::AR_SEP: c = (cs_wait_r == 2'h0) ? (wr ? dpt_pkg::CF_SEP_NW_WR : dpt_pkg::CF_ONE)
        : 3'({1'b0, cs_wait_r} + dpt_pkg::CF_ONE);
      dpt_pkg::AR_MUX: c = (cs_wait_r == dpt_pkg::CS_3W) ? dpt_pkg::CF_MUX_3W : dpt_pkg::CF_MUX_LO;
    endcase
    return c;
  endfunction

  // ****************************************
  // Per-channel registers
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < dpt_pkg::NCH; gi++)
    begin : g_ch
      logic sel, wc, ws, wd, wn;
      assign sel = ({ix[dpt_pkg::IW-1:2], 2'h0} == dpt_pkg::IW'(dpt_pkg::IX_STRIDE * gi)) && reg_wr;
      assign wc = sel && (ix[1:0] == dpt_pkg::IX_CTRL);
      assign ws = sel && (ix[1:0] == dpt_pkg::IX_SRC);
      assign wd = sel && (ix[1:0] == dpt_pkg::IX_DST);
      assign wn = sel && (ix[1:0] == dpt_pkg::IX_CNT);

      always_ff @(posedge clock)
        if (!rst_n)
          pend_r[gi] <= 1'b0;
        else if (dma_req[gi])
          pend_r[gi] <= 1'b1;
        else if (go && pick == gi)
          pend_r[gi] <= 1'b0;
        else if (wc && !reg_wdata[dpt_pkg::CB_PEND])
          pend_r[gi] <= 1'b0;

      always_ff @(posedge clock)
        if (!rst_n)
        begin
          en_r[gi] <= 1'b0;
          ldp_r[gi] <= 1'b0;
        end
        else if (wc)
        begin
          en_r[gi] <= reg_wdata[dpt_pkg::CB_EN];
          ldp_r[gi] <= reg_wdata[dpt_pkg::CB_EN];
        end
        else
        begin
          if (fin && ch_r == gi && uflow_r)
            en_r[gi] <= 1'b0;
          if (go && pick == gi)
            ldp_r[gi] <= 1'b0;
        end

      // Both-forward settings are software's fault; the source then wins
      always_ff @(posedge clock)
        if (!rst_n)
        begin
          sdir_r[gi] <= 1'b0;
          ddir_r[gi] <= 1'b0;
          u8c_r[gi] <= 1'b0;
          sarea_r[gi] <= dpt_pkg::AR_MEM;
          darea_r[gi] <= dpt_pkg::AR_MEM;
        end
        else if (wc)
        begin
          sdir_r[gi] <= reg_wdata[dpt_pkg::CB_SDIR];
          ddir_r[gi] <= reg_wdata[dpt_pkg::CB_DDIR];
          u8c_r[gi] <= reg_wdata[dpt_pkg::CB_UNIT8];
          sarea_r[gi] <= reg_wdata[dpt_pkg::CB_SAREA +: 2];
          darea_r[gi] <= reg_wdata[dpt_pkg::CB_DAREA +: 2];
        end

      always_ff @(posedge clock)
        if (!rst_n)
        begin
          src_r[gi] <= '0;
          dst_r[gi] <= '0;
        end
        else
        begin
          if (ws && (sdir_r[gi] || !en_r[gi]))
            src_r[gi] <= reg_wdata[dpt_pkg::AW-1:0];
          if (wd && (ddir_r[gi] || !en_r[gi]))
            dst_r[gi] <= reg_wdata[dpt_pkg::AW-1:0];
        end

      always_ff @(posedge clock)
        if (!rst_n)
        begin
          fwd_r[gi] <= '0;
          cnt_r[gi] <= '0;
          rld_r[gi] <= '0;
        end
        else
        begin
          if (wn)
            rld_r[gi] <= reg_wdata[15:0];
          if (go && pick == gi)
          begin
            fwd_r[gi] <= base + (u8c_r[gi] ? dpt_pkg::STEP_BYTE : dpt_pkg::STEP_WORD);
            cnt_r[gi] <= cbase - 16'h0001;
          end
        end
    end
  endgenerate

  always_ff @(posedge clock)
    if (!rst_n)
    begin
      mem_wait_r <= 1'b0;
      sfr_wait_select_r <= 1'b0;
      cs_wait_r <= 2'h0;
    end
    else if (reg_wr && ix == dpt_pkg::IX_WAIT)
    begin
      mem_wait_r <= reg_wdata[dpt_pkg::WB_MEM];
      sfr_wait_select_r <= reg_wdata[dpt_pkg::WB_SFR];
      cs_wait_r <= reg_wdata[dpt_pkg::WB_CS +: 2];
    end

  // ****************************************
  // Register read port
  // ****************************************
  always_comb
  begin
    logic c;
    c = ix[2];
    rd_nxt = '0;
    if (ix == dpt_pkg::IX_WAIT)
      rd_nxt = dpt_pkg::RW'({cs_wait_r, sfr_wait_select_r, mem_wait_r});
    else if (ix[dpt_pkg::IW-1:3] == '0)
      unique case (ix[1:0])
        dpt_pkg::IX_CTRL: rd_nxt = dpt_pkg::RW'({darea_r[c], sarea_r[c], u8c_r[c], ddir_r[c], sdir_r[c],
          pend_r[c], en_r[c]});
        dpt_pkg::IX_SRC: rd_nxt = dpt_pkg::RW'((sdir_r[c] && en_r[c]) ? fwd_r[c] : src_r[c]);
        dpt_pkg::IX_DST: rd_nxt = dpt_pkg::RW'((ddir_r[c] && en_r[c]) ? fwd_r[c] : dst_r[c]);
        dpt_pkg::IX_CNT: rd_nxt = dpt_pkg::RW'(cnt_r[c]);
      endcase
  end

  always_ff @(posedge clock)
    if (!rst_n)
      reg_rdata <= '0;
    else
      reg_rdata <= reg_rd ? rd_nxt : '0;

  // ****************************************
  // Transfer engine
  // ****************************************
  always_ff @(posedge clock)
    if (!rst_n)
    begin
      st_r <= dpt_pkg::ST_IDLE;
      ch_r <= 1'b0;
      part_r <= 1'b0;
      u8_r <= 1'b0;
      uflow_r <= 1'b0;
      wt_r <= '0;
      sa_r <= dpt_pkg::AR_MEM;
      da_r <= dpt_pkg::AR_MEM;
      saddr_r <= '0;
      daddr_r <= '0;
      cur_r <= '0;
      data_r <= '0;
    end
    else
      unique case (st_r)
        dpt_pkg::ST_IDLE:
          if (go)
          begin
            ch_r <= pick;
            u8_r <= u8c_r[pick];
            uflow_r <= (cbase == 16'h0000);
            sa_r <= sarea_r[pick];
            da_r <= darea_r[pick];
            saddr_r <= s_nxt;
            daddr_r <= d_nxt;
            cur_r <= s_nxt;
            part_r <= 1'b0;
            wt_r <= coef(sarea_r[pick], 1'b0) - dpt_pkg::CF_ONE;
            st_r <= dpt_pkg::ST_RD;
          end
        dpt_pkg::ST_RD:
          if (wt_r != 3'h0)
            wt_r <= wt_r - 3'h1;
          else if (!hold)
          begin
            if (u8_r || rd2)
            begin
              if (part_r)
                data_r[15:8] <= bus_rdata[7:0];
              else
                data_r[7:0] <= bus_rdata[7:0];
            end
            else
              data_r <= bus_rdata;
            if (!last)
            begin
              part_r <= 1'b1;
              cur_r <= saddr_r + dpt_pkg::STEP_BYTE;
              wt_r <= coef(sa_r, 1'b0) - dpt_pkg::CF_ONE;
            end
            else
            begin
              part_r <= 1'b0;
              cur_r <= daddr_r;
              wt_r <= coef(da_r, 1'b1) - dpt_pkg::CF_ONE;
              st_r <= dpt_pkg::ST_WR;
            end
          end
        dpt_pkg::ST_WR:
          if (wt_r != 3'h0)
            wt_r <= wt_r - 3'h1;
          else if (!hold)
          begin
            if (!last)
            begin
              part_r <= 1'b1;
              cur_r <= daddr_r + dpt_pkg::STEP_BYTE;
              wt_r <= coef(da_r, 1'b1) - dpt_pkg::CF_ONE;
            end
            else
              st_r <= dpt_pkg::ST_IDLE;
          end
        default:
          st_r <= dpt_pkg::ST_IDLE;
      endcase

  assign bus_o.rd = (st_r == dpt_pkg::ST_RD);
  assign bus_o.wr = (st_r == dpt_pkg::ST_WR);
  assign bus_o.byte_acc = u8_r || (bus_o.rd ? rd2 : (bus_o.wr && wr2));
  assign bus_o.addr = cur_r;
  // A byte unit always travels on the low lane, whatever its address
  assign bus_o.wdata = part_r ? {8'h00, data_r[15:8]} : data_r;

  // ****************************************
  // Checks
  // ****************************************
  logic [4:0] rdn_r, rexp_r;
  logic str_r;
  always_ff @(posedge clock)
    if (!rst_n || go)
    begin
      rdn_r <= '0;
      str_r <= 1'b0;
      rexp_r <= go ? 5'(coef(sarea_r[pick], 1'b0)) << (!u8c_r[pick] && (s_nxt[0] || bus8)) : '0;
    end
    else
    begin
      rdn_r <= rdn_r + 5'(bus_o.rd);
      str_r <= str_r || hold;
    end

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_pend_clear: assert property (reg_wr && ix == {4'h0, dpt_pkg::IX_CTRL} && !reg_wdata[dpt_pkg::CB_PEND]
    && !dma_req[0] |=> !pend_r[0]) else $error("pending flag not cleared");
  a_pend_no_set: assert property ($rose(pend_r[1]) |-> $past(dma_req[1]))
    else $error("pending flag set without request");
  a_src_locked: assert property (reg_wr && ix == {4'h0, dpt_pkg::IX_SRC} && !sdir_r[0] && en_r[0]
    |=> $stable(src_r[0])) else $error("fixed source written while enabled");
  a_dst_open: assert property (reg_wr && ix == {4'h1, dpt_pkg::IX_DST} && ddir_r[1]
    |=> dst_r[1] == $past(reg_wdata[dpt_pkg::AW-1:0])) else $error("forward destination write lost");
  a_src_live: assert property (reg_rd && ix == {4'h0, dpt_pkg::IX_SRC} && sdir_r[0] && en_r[0]
    |=> reg_rdata == dpt_pkg::RW'($past(fwd_r[0]))) else $error("source read not live");
  a_rd_then_wr: assert property ($rose(bus_o.wr) |-> $past(bus_o.rd) && !bus_o.rd)
    else $error("write not preceded by read");
  a_rd_cycles: assert property ($rose(bus_o.wr) && !str_r |-> rdn_r == rexp_r)
    else $error("read cycle count wrong");
  a_ready_hold: assert property (bus_o.rd && wt_r == 3'h0 && hold |=> bus_o.rd && $stable(cur_r))
    else $error("ready wait not honoured");
  a_byte_bus: assert property ((bus_o.rd || bus_o.wr) && bus8 |-> bus_o.byte_acc)
    else $error("8-bit bus not used");
  a_reload_cnt: assert property (go && ldp_r[pick] && !pick |=> cnt_r[0] == $past(rld_r[0]) - 16'h0001)
    else $error("counter not reloaded");

  c_odd_src: cover property ($rose(bus_o.rd) && saddr_r[0] && !u8_r);
  c_byte_bus: cover property (bus_o.wr && bus8 && part_r);
  c_stretch: cover property (bus_o.rd && hold);
  c_both_req: cover property (pend_r == 2'h3 && en_r == 2'h3);
endmodule

// >>> shared/dpt_pkg.sv
/*
  Shared constants and types of the two-channel DMA pointer and transfer-cycle block.
  Assumes one 50 MHz clock and a word-indexed register port.
*/
package dpt_pkg;
  localparam int NCH = 2;
  localparam int AW = 20;
  localparam int DW = 16;
  localparam int RW = 32;
  localparam int IW = 6;
  // Register word indices; byte address is index times four
  localparam logic [IW-1:0] IX_STRIDE = 6'h04;
  localparam logic [1:0] IX_CTRL = 2'h0;
  localparam logic [1:0] IX_SRC = 2'h1;
  localparam logic [1:0] IX_DST = 2'h2;
  localparam logic [1:0] IX_CNT = 2'h3;
  localparam logic [IW-1:0] IX_WAIT = 6'h08;
  // Channel control fields
  localparam int CB_EN = 0;
  localparam int CB_PEND = 1;
  localparam int CB_SDIR = 2;
  localparam int CB_DDIR = 3;
  localparam int CB_UNIT8 = 4;
  localparam int CB_SAREA = 5;
  localparam int CB_DAREA = 7;
  // Wait settings fields
  localparam int WB_MEM = 0;
  localparam int WB_SFR = 1;
  localparam int WB_CS = 2;
  // Areas
  localparam logic [1:0] AR_MEM = 2'h0;
  localparam logic [1:0] AR_SFR = 2'h1;
  localparam logic [1:0] AR_SEP = 2'h2;
  localparam logic [1:0] AR_MUX = 2'h3;
  // Cycle coefficients per bus access
  localparam logic [2:0] CF_ONE = 3'h1;
  localparam logic [2:0] CF_MEM_W = 3'h2;
  localparam logic [2:0] CF_SFR_1W = 3'h2;
  localparam logic [2:0] CF_SFR_2W = 3'h3;
  localparam logic [2:0] CF_SEP_NW_WR = 3'h2;
  localparam logic [2:0] CF_MUX_LO = 3'h3;
  localparam logic [2:0] CF_MUX_3W = 3'h4;
  localparam logic [1:0] CS_3W = 2'h3;
  localparam logic [AW-1:0] STEP_BYTE = 20'h00001;
  localparam logic [AW-1:0] STEP_WORD = 20'h00002;
  typedef enum logic [1:0] {ST_IDLE = 2'h0, ST_RD = 2'h1, ST_WR = 2'h3} dpt_state_t;
  typedef struct packed {
    logic rd;
    logic wr;
    logic byte_acc;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
  } dpt_bus_t;
endpackage

// >>> tb/dpt_mem_model.sv
/*
  Behavioural system bus for the DMA slice: one flat byte store for all areas.
  Assumes the shared clock; the bench asks for ready stalls through slow.
*/
`timescale 1ns/1ps
module dpt_mem_model (
  input wire logic clock,
  input wire logic slow,
  input wire dpt_pkg::dpt_bus_t bus_o,
  output logic bus_rdy_n,
  output logic [15:0] bus_rdata
);
  // ****************
  // Store and ready
  // ****************
  logic [7:0] mem [0:255];
  logic [7:0] a;
  logic busy;
  logic [1:0] stall_r = 2'h0;
  logic [15:0] last_r = 16'h0000;
  assign a = bus_o.addr[7:0];
  assign busy = bus_o.rd | bus_o.wr;
  // Two wait cycles per burst when slow, so a stretch is visible at the final cycle
  assign bus_rdy_n = slow & busy & (stall_r < 2'h2);
  // Idle or unused lane shows inverted data so a stale value never matches
  assign bus_rdata = bus_o.rd ? {bus_o.byte_acc ? ~mem[a] : mem[a + 8'h01], mem[a]} : ~last_r;
  // Plain always: the bench preloads the store directly between transfers
  always @(posedge clock)
  begin
    stall_r <= busy ? stall_r + {1'b0, bus_rdy_n} : 2'h0;
    if (bus_o.rd)
      last_r <= bus_rdata;
    if (bus_o.wr)
    begin
      mem[a] <= bus_o.wdata[7:0];
      if (!bus_o.byte_acc)
        mem[a + 8'h01] <= bus_o.wdata[15:8];
    end
  end
endmodule

// >>> tb/tb_top.sv
/*
  Self-checking bench for the DMA slice: pointer and flag access, cycle counts.
  Assumes the bus model answers every area from one byte store.
*/
`timescale 1ns/1ps
module tb_top;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [1:0] dma_req = 2'h0;
  logic ext_mode = 1'b0;
  logic byte_pin = 1'b0;
  logic slow = 1'b0;
  logic bus_rdy_n;
  logic [15:0] bus_rdata;
  dpt_pkg::dpt_bus_t bus_o;
  int n_errors = 0;
  int check_count = 0;
  int nrd;
  int nwr;

  dpt_dma dpt_dma_inst (
    .clock(clock),
    .rst_n(rst_n),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .dma_req(dma_req),
    .ext_mode(ext_mode),
    .byte_pin(byte_pin),
    .bus_rdy_n(bus_rdy_n),
    .bus_rdata(bus_rdata),
    .bus_o(bus_o)
  );
  dpt_mem_model dpt_mem_model_inst (
    .clock(clock),
    .slow(slow),
    .bus_o(bus_o),
    .bus_rdy_n(bus_rdy_n),
    .bus_rdata(bus_rdata)
  );

  initial forever #10 clock = ~clock;

  // ****************
  // Access tasks
  // ****************
  task automatic results;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic reg_w(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    chk(what, exp, reg_rdata);
  endtask
  task automatic poke(input logic [7:0] a, input logic [15:0] v);
    dpt_mem_model_inst.mem[a] = v[7:0];
    dpt_mem_model_inst.mem[a + 8'h01] = v[15:8];
  endtask
  function automatic logic [15:0] peek(input logic [7:0] a);
    return {dpt_mem_model_inst.mem[a + 8'h01], dpt_mem_model_inst.mem[a]};
  endfunction
  // Counts read and write cycles of one requested transfer
  task automatic xfer(input int ch);
    int i;
    bit seen_wr;
    seen_wr = 0;
    nrd = 0;
    nwr = 0;
    @(posedge clock);
    dma_req[ch] <= 1'b1;
    @(posedge clock);
    dma_req <= 2'h0;
    for (i = 0; i < 300; i++)
    begin
      @(posedge clock);
      #1;
      if (bus_o.rd === 1'b1 && seen_wr)
        chk("read after write", 0, 1);
      if (bus_o.rd === 1'b1)
        nrd++;
      if (bus_o.wr === 1'b1)
        seen_wr = 1;
      if (bus_o.wr === 1'b1)
        nwr++;
      if (nrd + nwr > 0 && bus_o.rd !== 1'b1 && bus_o.wr !== 1'b1)
        break;
    end
    if (i == 300)
    begin
      n_errors++;
      $display("MISMATCH transfer end expected idle seen busy");
      results();
    end
  endtask
  // cfg: [8:7] dst area, [6:5] src area, [4] byte unit; both directions fixed
  task automatic xcase(input logic ext, input logic bp, input logic [8:0] cfg, input logic [3:0] wset,
                       input logic [7:0] s, input logic [7:0] t, input logic sl, input int er, input int ew);
    reg_w(8'h00, 32'h0);
    ext_mode <= ext;
    byte_pin <= bp;
    slow <= sl;
    reg_w(8'h20, {28'h0, wset});
    reg_w(8'h04, {24'h0, s});
    reg_w(8'h08, {24'h0, t});
    poke(s, {t, s ^ 8'h5a});
    reg_w(8'h00, {23'h0, cfg} | 32'h1);
    xfer(0);
    chk("read cycles", er, nrd);
    chk("write cycles", ew, nwr);
    if (!cfg[4])
      chk("moved word", {16'h0, t, s ^ 8'h5a}, {16'h0, peek(t)});
    else
      chk("moved byte", {24'h0, s ^ 8'h5a}, {16'h0, peek(t) & 16'h00ff});
  endtask

  // ****************
  // Main sequence
  // ****************
  initial
  begin
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    rchk("ctrl reset", 8'h00, 32'h0);
    rchk("wait reset", 8'h20, 32'h0);
    reg_w(8'h30, 32'hffffffff);
    rchk("unmapped", 8'h30, 32'h0);
    @(posedge clock);
    dma_req <= 2'h2;
    @(posedge clock);
    dma_req <= 2'h0;
    rchk("pend set", 8'h10, 32'h2);
    reg_w(8'h10, 32'h2);
    rchk("pend kept", 8'h10, 32'h2);
    reg_w(8'h10, 32'h0);
    rchk("pend cleared", 8'h10, 32'h0);
    reg_w(8'h04, 32'h10);
    reg_w(8'h08, 32'h40);
    reg_w(8'h00, 32'h1);
    reg_w(8'h04, 32'h55);
    rchk("fixed src", 8'h04, 32'h10);
    reg_w(8'h08, 32'h77);
    rchk("fixed dst", 8'h08, 32'h40);
    reg_w(8'h00, 32'h0);
    reg_w(8'h04, 32'h20);
    poke(8'h20, 16'h3412);
    reg_w(8'h0c, 32'h3);
    reg_w(8'h00, 32'h5);
    xfer(0);
    chk("src fwd word", 32'h3412, {16'h0, peek(8'h40)});
    rchk("live src", 8'h04, 32'h22);
    rchk("counter", 8'h0c, 32'h2);
    reg_w(8'h04, 32'h30);
    rchk("live src kept", 8'h04, 32'h22);
    reg_w(8'h00, 32'h4);
    rchk("written src", 8'h04, 32'h30);
    reg_w(8'h14, 32'h60);
    poke(8'h60, 16'hbc9a);
    reg_w(8'h18, 32'h70);
    reg_w(8'h1c, 32'h1);
    reg_w(8'h10, 32'h9);
    xfer(1);
    chk("dst fwd word", 32'hbc9a, {16'h0, peek(8'h70)});
    rchk("live dst", 8'h18, 32'h72);
    reg_w(8'h18, 32'h88);
    reg_w(8'h10, 32'h8);
    rchk("written dst", 8'h18, 32'h88);
    xcase(0, 0, 9'h000, 4'h0, 8'h10, 8'h80, 0, 1, 1);
    xcase(0, 0, 9'h000, 4'h0, 8'h21, 8'h90, 0, 2, 1);
    xcase(0, 0, 9'h000, 4'h0, 8'h30, 8'ha1, 0, 1, 2);
    xcase(0, 0, 9'h000, 4'h0, 8'h43, 8'hb1, 0, 2, 2);
    xcase(1, 1, 9'h000, 4'h0, 8'h50, 8'hc0, 0, 2, 2);
    xcase(0, 1, 9'h000, 4'h0, 8'h62, 8'hd0, 0, 1, 1);
    xcase(0, 0, 9'h010, 4'h0, 8'h71, 8'he1, 0, 1, 1);
    xcase(0, 0, 9'h000, 4'h1, 8'h12, 8'h82, 0, 2, 2);
    xcase(0, 0, 9'h0a0, 4'h0, 8'h14, 8'h84, 0, 2, 2);
    xcase(0, 0, 9'h0a0, 4'h2, 8'h16, 8'h86, 0, 3, 3);
    xcase(1, 0, 9'h140, 4'h0, 8'h18, 8'h88, 0, 1, 2);
    xcase(1, 0, 9'h140, 4'hc, 8'h1a, 8'h8a, 0, 4, 4);
    xcase(1, 0, 9'h1e0, 4'h0, 8'h1c, 8'h8c, 0, 3, 3);
    xcase(1, 0, 9'h1e0, 4'hc, 8'h24, 8'h94, 0, 4, 4);
    xcase(1, 0, 9'h040, 4'h0, 8'h26, 8'h96, 1, 3, 1);
    results();
  end
endmodule
